// ### ras_pkg.sv
// Constants for the random alarm scheduler: register map, field limits,
// reset values and timing figures.
// Assumes a 40 MHz system clock and a 32-bit APB register bus.
package ras_pkg;
   // Register byte offsets
   localparam logic [7:0] OFS_CTRL = 8'h00;      // Command word
   localparam logic [7:0] OFS_PERCENT = 8'h04;   // Random alarm percentage
   localparam logic [7:0] OFS_TONE = 8'h08;      // Random alarm tone
   localparam logic [7:0] OFS_LOUD = 8'h0C;      // Random alarm loudness
   localparam logic [7:0] OFS_VOLMIN = 8'h10;    // Minimum volume floor
   localparam logic [7:0] OFS_STYLE = 8'h14;     // Random display style
   localparam logic [7:0] OFS_SENS = 8'h18;      // Overall sensitivity
   localparam logic [7:0] OFS_FREQ = 8'h1C;      // Operating frequency
   localparam logic [7:0] OFS_FAST = 8'h20;      // Fast object response
   localparam logic [7:0] OFS_SLOW = 8'h24;      // Slow object response
   localparam logic [7:0] OFS_NONALARM = 8'h28;  // Non-alarm pass count
   localparam logic [7:0] OFS_RNDCNT = 8'h2C;    // Random alarm count
   localparam logic [7:0] OFS_GROUP = 8'h30;     // Group position and issued
   localparam logic [7:0] OFS_IRQSTAT = 8'h34;   // Sticky event flags
   localparam logic [7:0] OFS_IRQMASK = 8'h38;   // Event mask
   localparam logic [7:0] OFS_ZONE0 = 8'h40;     // Zone 0, zones follow by 4
   localparam logic [7:0] OFS_ZONE7 = 8'h5C;     // Last zone
   // Field positions
   localparam int CTRL_CLRSTAT = 0;   // Clear statistics command bit
   localparam int IRQ_RND = 0;        // Random alarm fired
   localparam int IRQ_GROUP = 1;      // Group of passes completed
   localparam int IRQ_REJECT = 2;     // Out of range write refused
   localparam int GRP_ISSUED = 8;     // Issued count position in group word
   // Limits and reset values
   localparam logic [6:0] GROUP_SIZE = 7'h64;   // Passes per group
   localparam logic [6:0] PCT_MAX = 7'h64;
   localparam logic [6:0] PCT_RST = 7'h00;
   localparam logic [2:0] TONE_MIN = 3'h1;
   localparam logic [2:0] TONE_MAX = 3'h6;
   localparam logic [2:0] TONE_RST = 3'h5;
   localparam logic [3:0] LOUD_MAX = 4'h8;
   localparam logic [3:0] LOUD_RST = 4'h2;
   localparam logic [3:0] VOLMIN_RST = 4'h2;
   localparam logic [6:0] SENS_MIN = 7'h01;
   localparam logic [6:0] SENS_MAX = 7'h64;
   localparam logic [6:0] SENS_RST = 7'h32;
   localparam logic [7:0] ZONE_RST = 8'h64;
   localparam logic [1:0] FREQ_RST = 2'h0;      // F1, single detector
   localparam logic [1:0] FAST_MIN = 2'h1;
   localparam logic [1:0] FAST_MAX = 2'h3;
   localparam logic [1:0] FAST_RST = 2'h2;
   localparam logic [1:0] SLOW_MIN = 2'h1;
   localparam logic [1:0] SLOW_MAX = 2'h2;
   localparam logic [1:0] SLOW_RST = 2'h2;
   localparam logic [15:0] LFSR_SEED = 16'hACE1;
   // Timing
   localparam int CLK_KHZ = 40000;          // 40 MHz
   localparam int ALARM_MS = 1000;          // Random alarm indication time
   localparam int FLASH_MS = 125;           // Red lamp half period
   localparam int ALARM_CYCLES = ALARM_MS * CLK_KHZ;
   localparam int FLASH_CYCLES = FLASH_MS * CLK_KHZ;
   // Display styles
   typedef enum logic [0:0] {
      STYLE_NORMAL = 1'b0,
      STYLE_PATTERN = 1'b1
   } ras_style_e;
endpackage : ras_pkg

// ### ras_random_alarm_scheduler.sv
// Top of the random alarm scheduler with its APB register file.
// Assumes pass events come from front end logic on the same clock.
//
// The register offsets and the APB interface to the registers were decided locally.
`timescale 1ns/100ps
module ras_random_alarm_scheduler #(
   parameter int ALARM_CYCLES = ras_pkg::ALARM_CYCLES, // Indication length
   parameter int FLASH_CYCLES = ras_pkg::FLASH_CYCLES  // Lamp half period
) (
   input wire logic clk,                 // System clock
   input wire logic sys_rst,             // Asynchronous reset
   input wire logic psel,                // APB select
   input wire logic penable,             // APB access phase
   input wire logic pwrite,              // APB direction
   input wire logic [7:0] paddr,         // APB byte address
   input wire logic [31:0] pwdata,       // APB write data
   output logic pready,                  // APB ready
   output logic [31:0] prdata,           // APB read data
   output logic pslverr,                 // APB error, unmapped address
   input wire logic passDone,            // Pulse: one person passed
   input wire logic naturalAlarm,        // Pass raised a metal alarm
   input wire logic networkPassCountClear, // Pulse: network clear
   output logic randomAlarmPulse,        // Pulse: random alarm chosen
   output logic redLamp,                 // Flashing red indicator
   output logic [7:0] zoneLamps,         // Zone indicators
   output logic displayNormalAlarm,      // Show as a natural alarm
   output logic displayPattern,          // Show full pattern bar
   output logic sounderOn,               // Audible output active
   output logic [2:0] sounderTone,       // Tone while sounding
   output logic [3:0] sounderLoudness,   // Loudness while sounding
   output logic [6:0] overallSens,       // Overall sensitivity
   output logic [63:0] zoneSens,         // Effective zone sensitivities
   output logic [1:0] operatingFrequencySelect, // 0 is F1
   output logic [1:0] fastObjectResponse, // Fast speed response
   output logic [1:0] slowObjectResponse, // Slow speed response
   output logic irq                      // Level interrupt
);

   // Module state, apart from the output flops
   typedef struct packed {
      logic ready;            // Access phase answer
      logic [31:0] rdata;     // Read data
      logic slverr;           // Error answer
      logic [6:0] pct;        // Random alarm percentage
      logic [2:0] tone;       // Random alarm tone
      logic [3:0] loud;       // Random alarm loudness
      logic [3:0] volMin;     // Loudness floor
      logic style;            // Random display style
      logic [6:0] sens;       // Overall sensitivity
      logic [7:0][7:0] zonePct; // Zone percentages
      logic [7:0][7:0] zoneEff; // Scaled zone sensitivities
      logic [1:0] freq;       // Operating frequency
      logic [1:0] fast;       // Fast response
      logic [1:0] slow;       // Slow response
      logic [6:0] groupPos;   // Passes counted in group
      logic [6:0] issued;     // Random alarms in group
      logic [15:0] nonAlarmCnt; // Non-alarm passes
      logic [15:0] rndCnt;    // Random alarms generated
      logic [15:0] lfsr;      // Pseudo random source
      logic [25:0] alarmCnt;  // Indication time left
      logic [25:0] flashCnt;  // Lamp toggle timer
      logic red;              // Red lamp
      logic pulse;            // Random alarm pulse
      logic [2:0] irqStat;    // Sticky events
      logic [2:0] irqMask;    // Event enables
      logic irqOut;           // Interrupt line
   } ras_state_s;

   ras_state_s state_q;
   ras_state_s state_d;

   // Zone scaling: overall times percentage over hundred
   function automatic logic [7:0] ras_scale(input logic [6:0] s, input logic [7:0] p);
      logic [14:0] prod;
      prod = 15'(s) * 15'(p);
      return 8'(prod / 15'd100);
   endfunction : ras_scale

   // Byte address to zone index
   function automatic logic [2:0] ras_zone(input logic [7:0] a);
      return a[4:2];
   endfunction : ras_zone

   logic setup;              // Access phase, not yet answered
   logic commit;             // Access phase completes at this edge
   logic wr;                 // Write completes
   logic mapped;             // Address belongs to a register
   logic isZone;             // Address is a zone register
   logic goodPass;           // Pass without natural alarm
   logic [6:0] remain;       // Passes left in group
   logic [6:0] need;         // Random alarms still owed
   logic [13:0] draw;        // Scaled random draw
   logic fire;               // Random alarm for this pass
   logic groupEnd;           // Last pass of group
   logic groupClr;           // Group counter clear
   logic statClr;            // Statistics clear
   logic reject;             // Write value refused
   logic [31:0] rd;          // Read mux
   logic [2:0] ev;           // Events this cycle
   logic [3:0] effLoud;      // Floored loudness

   // Next state: bus, settings, scheduler, indication
   always_comb begin
      state_d = state_q;
      setup = psel && penable && !state_q.ready;
      commit = psel && penable && state_q.ready;
      wr = commit && pwrite;
      isZone = (paddr >= ras_pkg::OFS_ZONE0) && (paddr <= ras_pkg::OFS_ZONE7) &&
         (paddr[1:0] == 2'b00);
      mapped = isZone || (paddr[1:0] == 2'b00 && paddr <= ras_pkg::OFS_IRQMASK);
      reject = 1'b0;
      statClr = 1'b0;
      rd = 32'h0000_0000;
      ev = 3'b000;
      state_d.lfsr = {state_q.lfsr[14:0],
         state_q.lfsr[15] ^ state_q.lfsr[13] ^ state_q.lfsr[12] ^ state_q.lfsr[10]};

      // Read mux, address decode
      if (paddr == ras_pkg::OFS_PERCENT) begin
         rd = 32'(state_q.pct);
      end else if (paddr == ras_pkg::OFS_TONE) begin
         rd = 32'(state_q.tone);
      end else if (paddr == ras_pkg::OFS_LOUD) begin
         rd = 32'(state_q.loud);
      end else if (paddr == ras_pkg::OFS_VOLMIN) begin
         rd = 32'(state_q.volMin);
      end else if (paddr == ras_pkg::OFS_STYLE) begin
         rd = 32'(state_q.style);
      end else if (paddr == ras_pkg::OFS_SENS) begin
         rd = 32'(state_q.sens);
      end else if (paddr == ras_pkg::OFS_FREQ) begin
         rd = 32'(state_q.freq);
      end else if (paddr == ras_pkg::OFS_FAST) begin
         rd = 32'(state_q.fast);
      end else if (paddr == ras_pkg::OFS_SLOW) begin
         rd = 32'(state_q.slow);
      end else if (paddr == ras_pkg::OFS_NONALARM) begin
         rd = 32'(state_q.nonAlarmCnt);
      end else if (paddr == ras_pkg::OFS_RNDCNT) begin
         rd = 32'(state_q.rndCnt);
      end else if (paddr == ras_pkg::OFS_GROUP) begin
         rd = 32'(state_q.groupPos) | (32'(state_q.issued) << ras_pkg::GRP_ISSUED);
      end else if (paddr == ras_pkg::OFS_IRQSTAT) begin
         rd = 32'(state_q.irqStat);
      end else if (paddr == ras_pkg::OFS_IRQMASK) begin
         rd = 32'(state_q.irqMask);
      end else if (isZone) begin
         rd = 32'(state_q.zonePct[ras_zone(paddr)]);
      end else begin
         rd = 32'h0000_0000;   // Command word and holes read zero
      end

      // One wait state; data and error are registered at the same edge as ready
      state_d.ready = setup;
      if (setup) begin
         state_d.rdata = pwrite ? 32'h0000_0000 : rd;
         state_d.slverr = !mapped;
      end else begin
         state_d.rdata = 32'h0000_0000;
         state_d.slverr = 1'b0;
      end

      // Register writes; each setting except the event mask keeps its old value if out of range
      groupClr = networkPassCountClear;
      if (wr && mapped) begin
         if (paddr == ras_pkg::OFS_CTRL) begin
            statClr = pwdata[ras_pkg::CTRL_CLRSTAT];
         end else if (paddr == ras_pkg::OFS_PERCENT) begin
            if (pwdata <= 32'(ras_pkg::PCT_MAX)) begin
               state_d.pct = pwdata[6:0];
               groupClr = 1'b1;
            end else begin
               reject = 1'b1;
            end
         end else if (paddr == ras_pkg::OFS_TONE) begin
            if (pwdata >= 32'(ras_pkg::TONE_MIN) && pwdata <= 32'(ras_pkg::TONE_MAX)) begin
               state_d.tone = pwdata[2:0];
            end else begin
               reject = 1'b1;
            end
         end else if (paddr == ras_pkg::OFS_LOUD) begin
            if (pwdata <= 32'(ras_pkg::LOUD_MAX)) begin
               state_d.loud = pwdata[3:0];
            end else begin
               reject = 1'b1;
            end
         end else if (paddr == ras_pkg::OFS_VOLMIN) begin
            if (pwdata <= 32'(ras_pkg::LOUD_MAX)) begin
               state_d.volMin = pwdata[3:0];
            end else begin
               reject = 1'b1;
            end
         end else if (paddr == ras_pkg::OFS_STYLE) begin
            if (pwdata <= 32'h0000_0001) begin
               state_d.style = pwdata[0];
            end else begin
               reject = 1'b1;
            end
         end else if (paddr == ras_pkg::OFS_SENS) begin
            if (pwdata >= 32'(ras_pkg::SENS_MIN) && pwdata <= 32'(ras_pkg::SENS_MAX)) begin
               state_d.sens = pwdata[6:0];
            end else begin
               reject = 1'b1;
            end
         end else if (paddr == ras_pkg::OFS_FREQ) begin
            if (pwdata <= 32'h0000_0003) begin
               state_d.freq = pwdata[1:0];
            end else begin
               reject = 1'b1;
            end
         end else if (paddr == ras_pkg::OFS_FAST) begin
            if (pwdata >= 32'(ras_pkg::FAST_MIN) && pwdata <= 32'(ras_pkg::FAST_MAX)) begin
               state_d.fast = pwdata[1:0];
            end else begin
               reject = 1'b1;
            end
         end else if (paddr == ras_pkg::OFS_SLOW) begin
            if (pwdata >= 32'(ras_pkg::SLOW_MIN) && pwdata <= 32'(ras_pkg::SLOW_MAX)) begin
               state_d.slow = pwdata[1:0];
            end else begin
               reject = 1'b1;
            end
         end else if (paddr == ras_pkg::OFS_IRQMASK) begin
            state_d.irqMask = pwdata[2:0];
         end else if (isZone) begin
            // Only the zone scale changes; overall value is not touched
            if (pwdata <= 32'h0000_00FF) begin
               state_d.zonePct[ras_zone(paddr)] = pwdata[7:0];
            end else begin
               reject = 1'b1;
            end
         end else begin
            reject = 1'b0;   // Counters and group word are read only
         end
      end

      // Effective zone sensitivity tracks the stored settings
      for (int z = 0; z < 8; z++) begin
         state_d.zoneEff[z] = ras_scale(state_q.sens, state_q.zonePct[z]);
      end

      // Scheduler: chance of firing is owed alarms over passes left,
      // forced once they are equal, so the group ends exactly on count
      goodPass = passDone && !naturalAlarm;
      remain = ras_pkg::GROUP_SIZE - state_q.groupPos;
      need = state_q.pct - state_q.issued;
      draw = 14'(state_q.lfsr[6:0]) * 14'(remain);
      fire = goodPass && (need != 7'h00) &&
         ((need >= remain) || (draw < {need, 7'h00}));
      groupEnd = goodPass && (state_q.groupPos == ras_pkg::GROUP_SIZE - 7'h01);
      state_d.pulse = fire;
      if (goodPass) begin
         state_d.nonAlarmCnt = state_q.nonAlarmCnt + 16'h0001;
         if (groupEnd) begin
            state_d.groupPos = 7'h00;
            state_d.issued = 7'h00;
         end else begin
            state_d.groupPos = state_q.groupPos + 7'h01;
            state_d.issued = state_q.issued + 7'(fire);
         end
      end
      if (fire) begin
         state_d.rndCnt = state_q.rndCnt + 16'h0001;
      end
      // Clears win over a pass in the same cycle
      if (statClr) begin
         state_d.nonAlarmCnt = 16'h0000;
         state_d.rndCnt = 16'h0000;
      end
      if (groupClr || statClr) begin
         state_d.groupPos = 7'h00;
         state_d.issued = 7'h00;
      end

      // Indication timer and red lamp flashing; a new alarm restarts it
      if (fire) begin
         state_d.alarmCnt = 26'(ALARM_CYCLES);
         state_d.flashCnt = 26'(FLASH_CYCLES);
         state_d.red = 1'b1;
      end else if (state_q.alarmCnt != 26'h0) begin
         state_d.alarmCnt = state_q.alarmCnt - 26'h1;
         if (state_q.flashCnt == 26'h0) begin
            state_d.flashCnt = 26'(FLASH_CYCLES);
            state_d.red = !state_q.red;
         end else begin
            state_d.flashCnt = state_q.flashCnt - 26'h1;
         end
         if (state_q.alarmCnt == 26'h1) begin
            state_d.red = 1'b0;
         end
      end else begin
         state_d.red = 1'b0;
      end

      // Interrupt flags: set wins over a write-one clear
      ev[ras_pkg::IRQ_RND] = fire;
      ev[ras_pkg::IRQ_GROUP] = groupEnd;
      ev[ras_pkg::IRQ_REJECT] = reject;
      if (wr && paddr == ras_pkg::OFS_IRQSTAT) begin
         state_d.irqStat = state_q.irqStat & ~pwdata[2:0];
      end
      state_d.irqStat = state_d.irqStat | ev;
      state_d.irqOut = |(state_d.irqStat & state_d.irqMask);

      effLoud = (state_q.loud < state_q.volMin) ? state_q.volMin : state_q.loud;
   end

   // State register
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         state_q <= '0;
         state_q.pct <= ras_pkg::PCT_RST;
         state_q.tone <= ras_pkg::TONE_RST;
         state_q.loud <= ras_pkg::LOUD_RST;
         state_q.volMin <= ras_pkg::VOLMIN_RST;
         state_q.style <= ras_pkg::STYLE_NORMAL;
         state_q.sens <= ras_pkg::SENS_RST;
         state_q.zonePct <= {8{ras_pkg::ZONE_RST}};
         state_q.zoneEff <= {8{{1'b0, ras_pkg::SENS_RST}}}; // Overall at 100 percent
         state_q.freq <= ras_pkg::FREQ_RST;
         state_q.fast <= ras_pkg::FAST_RST;
         state_q.slow <= ras_pkg::SLOW_RST;
         state_q.lfsr <= ras_pkg::LFSR_SEED;
      end else begin
         state_q <= state_d;
      end
   end

   // Outputs: indication flops, registered so every port is a flip-flop
   logic active_q;
   logic [3:0] loud_q;
   logic dispNormal_q;       // Display as natural alarm
   logic dispPattern_q;      // Display full pattern bar
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         active_q <= 1'b0;
         loud_q <= ras_pkg::LOUD_RST;
         dispNormal_q <= 1'b0;
         dispPattern_q <= 1'b0;
      end else begin
         active_q <= state_d.alarmCnt != 26'h0;
         loud_q <= effLoud;
         dispNormal_q <= (state_d.alarmCnt != 26'h0) && !state_d.style;
         dispPattern_q <= (state_d.alarmCnt != 26'h0) && state_d.style;
      end
   end

   assign pready = state_q.ready;
   assign prdata = state_q.rdata;
   assign pslverr = state_q.slverr;
   assign randomAlarmPulse = state_q.pulse;
   assign redLamp = state_q.red;
   assign zoneLamps = {8{active_q}};
   assign displayNormalAlarm = dispNormal_q;
   assign displayPattern = dispPattern_q;
   assign sounderOn = active_q;
   assign sounderTone = state_q.tone;
   assign sounderLoudness = loud_q;
   assign overallSens = state_q.sens;
   assign zoneSens = state_q.zoneEff;
   assign operatingFrequencySelect = state_q.freq;
   assign fastObjectResponse = state_q.fast;
   assign slowObjectResponse = state_q.slow;
   assign irq = state_q.irqOut;
endmodule : ras_random_alarm_scheduler

// ### ras_front_end_model.sv
// Front end model: turns a bench request into pass events.
// Assumes requests arrive on the same clock as the scheduler.
`timescale 1ns/100ps
module ras_front_end_model (
   input wire logic clk, // System clock
   input wire logic passReq, // Bench asks for a pass
   input wire logic metal, // Pass carries metal
   output logic passDone, // Pass pulse to scheduler
   output logic naturalAlarm // Metal flag, meaningful with pass only
);
   // Outside a pass the flag toggles so a stale value is never trusted
   always_ff @(posedge clk) begin
      passDone <= passReq;
      naturalAlarm <= passReq ? metal : !(naturalAlarm === 1'b1);
   end
endmodule : ras_front_end_model

// ### ras_random_alarm_scheduler_sva.sv
// Checker on the scheduler ports: pass, indication and setting ranges.
// Assumes one clock domain, bound onto the scheduler top.
`timescale 1ns/100ps
module ras_random_alarm_scheduler_sva (
   input wire logic clk, // Clock
   input wire logic sys_rst, // Reset
   input wire logic psel, // APB select
   input wire logic penable, // APB enable
   input wire logic pready, // APB ready
   input wire logic passDone, // Pass pulse
   input wire logic naturalAlarm, // Metal flag
   input wire logic randomAlarmPulse, // Random alarm
   input wire logic redLamp, // Red lamp
   input wire logic [7:0] zoneLamps, // Zone lamps
   input wire logic sounderOn, // Sounder
   input wire logic [2:0] sounderTone, // Tone
   input wire logic [3:0] sounderLoudness, // Loudness
   input wire logic displayNormalAlarm, // Normal display
   input wire logic displayPattern, // Pattern display
   input wire logic [6:0] overallSens, // Sensitivity
   input wire logic [1:0] fastObjectResponse, // Fast response
   input wire logic [1:0] slowObjectResponse // Slow response
);
   // All checks share the one clock and reset
   default clocking cb @(posedge clk); endclocking
   default disable iff (sys_rst);
   chk_apb_one_wait: assert property (psel && penable && !pready |=> pready)
      else $error("pready missing after one wait");
   chk_natural_skip: assert property (passDone && naturalAlarm |=> !randomAlarmPulse)
      else $error("random alarm on natural alarm pass");
   chk_idle_quiet: assert property (!passDone |=> !randomAlarmPulse)
      else $error("random alarm without pass");
   chk_alarm_lamps: assert property (randomAlarmPulse |-> zoneLamps == 8'hFF && sounderOn && redLamp)
      else $error("indication incomplete");
   chk_tone_legal: assert property (sounderOn |-> sounderTone inside {[3'h1:3'h6]})
      else $error("tone out of range");
   chk_loud_legal: assert property (sounderLoudness <= 4'h8)
      else $error("loudness out of range");
   chk_sens_legal: assert property (overallSens inside {[7'h01:7'h64]})
      else $error("sensitivity out of range");
   chk_style_pick: assert property ((displayNormalAlarm || displayPattern) == sounderOn
      && !(displayNormalAlarm && displayPattern))
      else $error("display style wrong");
   chk_speed_legal: assert property (slowObjectResponse inside {2'h1, 2'h2}
      && fastObjectResponse inside {[2'h1:2'h3]})
      else $error("speed response out of range");
endmodule : ras_random_alarm_scheduler_sva
bind ras_random_alarm_scheduler ras_random_alarm_scheduler_sva u_sva (.clk(clk), .sys_rst(sys_rst),
   .psel(psel), .penable(penable), .pready(pready), .passDone(passDone),
   .naturalAlarm(naturalAlarm), .randomAlarmPulse(randomAlarmPulse), .redLamp(redLamp),
   .zoneLamps(zoneLamps), .sounderOn(sounderOn), .sounderTone(sounderTone),
   .sounderLoudness(sounderLoudness), .displayNormalAlarm(displayNormalAlarm),
   .displayPattern(displayPattern), .overallSens(overallSens),
   .fastObjectResponse(fastObjectResponse), .slowObjectResponse(slowObjectResponse));

// ### random_alarm_scheduler_bench.sv
// Bench for the scheduler: APB master, pass stimulus and counting model.
// Assumes short indication parameters and the front end model.
`timescale 1ns/100ps
module random_alarm_scheduler_bench;
   logic clk = 0, sys_rst = 1, psel = 0, penable = 0, pwrite = 0, netClr = 0;
   logic passReq = 0, metal = 0, passDone, naturalAlarm, pready, pslverr, pulse, irq;
   logic redLamp, dispN, dispP, sndOn;
   logic [7:0] paddr = 0, zoneLamps;
   logic [31:0] pwdata = 0, prdata;
   logic [2:0] tone;
   logic [3:0] loud;
   logic [6:0] sens;
   logic [63:0] zoneSens;
   logic [1:0] freq, fast, slow;
   int n_mismatch = 0, cmp_count = 0, nPulse = 0, expTone = 5, expLoud = 2, expStyle = 0;
   // Register, bad value, value that must survive
   logic [7:0] ba[9] = '{8'h08, 8'h08, 8'h0C, 8'h18, 8'h18, 8'h20, 8'h20, 8'h24, 8'h04};
   int bv[9] = '{0, 7, 9, 0, 101, 0, 4, 3, 101};
   int kv[9] = '{5, 5, 2, 50, 50, 2, 2, 2, 0};
   initial forever #12.5 clk = ~clk;
   ras_front_end_model u_fe (.clk(clk), .passReq(passReq), .metal(metal),
      .passDone(passDone), .naturalAlarm(naturalAlarm));
   ras_random_alarm_scheduler #(.ALARM_CYCLES(20), .FLASH_CYCLES(4)) u_dut (.clk(clk),
      .sys_rst(sys_rst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
      .passDone(passDone), .naturalAlarm(naturalAlarm), .networkPassCountClear(netClr),
      .randomAlarmPulse(pulse), .redLamp(redLamp), .zoneLamps(zoneLamps),
      .displayNormalAlarm(dispN), .displayPattern(dispP), .sounderOn(sndOn),
      .sounderTone(tone), .sounderLoudness(loud), .overallSens(sens), .zoneSens(zoneSens),
      .operatingFrequencySelect(freq), .fastObjectResponse(fast),
      .slowObjectResponse(slow), .irq(irq));
   task automatic complete_run;
      $display("mismatches %0d comparisons %0d", n_mismatch, cmp_count);
      if (n_mismatch == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask : complete_run
   task automatic cmp(input string nm, input logic [31:0] e, input logic [31:0] g);
      cmp_count++;
      if (g !== e) begin
         n_mismatch++;
         $display("unexpected %s expected %h seen %h", nm, e, g);
      end
   endtask : cmp
   // One APB transfer; pready and the answer are taken at the rising edge
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
      output logic [31:0] r, output logic err);
      int i = 0;
      @(posedge clk);
      psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
      @(posedge clk);
      penable <= 1;
      do begin
         @(posedge clk);
         i++;
      end while (pready !== 1'b1 && i < 20);
      r = prdata; err = pslverr;
      if (pready !== 1'b1) begin n_mismatch++; complete_run(); end
      psel <= 0; penable <= 0;
   endtask : apb
   task automatic wr(input logic [7:0] a, input int d);
      logic [31:0] r; logic e;
      apb(1'b1, a, d, r, e);
   endtask : wr
   task automatic rdc(input logic [7:0] a, input int e, input int m = -1);
      logic [31:0] r; logic x;
      apb(1'b0, a, 32'h0000_0000, r, x);
      cmp($sformatf("reg %h", a), e & m, r & m);
   endtask : rdc
   // Back to back passes until n of them carried no metal
   task automatic passes(input int n);
      int na = 0, k = 0; logic m;
      while (na < n && k < 1000) begin
         @(posedge clk);
         m = ($urandom % 4) == 0;
         passReq <= 1; metal <= m;
         if (!m) na++;
         k++;
      end
      if (na < n) begin n_mismatch++; complete_run(); end
      @(posedge clk); passReq <= 0;
      repeat (4) @(posedge clk);
   endtask : passes
   task automatic irqc(input logic e);
      repeat (2) @(negedge clk);
      cmp("irq", e, irq);
   endtask : irqc
   // Every random alarm is checked for its tone, loudness and style
   always @(negedge clk) if (pulse === 1'b1) begin
      nPulse++;
      cmp("tone", expTone, tone);
      cmp("loud", expLoud, loud);
      cmp("style", expStyle, dispP);
   end
   initial begin
      logic [31:0] r; logic e;
      void'($urandom(31589));
      repeat (5) @(posedge clk);
      sys_rst <= 0;
      foreach (ba[i]) rdc(ba[i], kv[i]);
      for (int z = 0; z < 8; z++) rdc(8'h40 + 4 * z, 100);
      foreach (ba[i]) begin wr(ba[i], bv[i]); rdc(ba[i], kv[i]); end
      rdc(8'h34, 4, 4);
      irqc(0);
      wr(8'h38, 4); irqc(1);
      wr(8'h34, 4); irqc(0);
      apb(1'b0, 8'h3C, 0, r, e); cmp("slverr", 1, e); cmp("unmapped", 0, r);
      for (int f = 0; f < 4; f++) begin wr(8'h1C, f); irqc(0); cmp("freq", f, freq); end
      wr(8'h4C, 200); irqc(0); cmp("zone3", 50 * 200 / 100, zoneSens[31:24]);
      cmp("sens", 50, sens); rdc(8'h18, 50);
      wr(8'h14, 1); wr(8'h0C, 0); wr(8'h10, 3); wr(8'h08, 3); wr(8'h38, 1);
      expStyle = 1; expLoud = 3; expTone = 3;
      wr(8'h04, 15); wr(8'h00, 1); nPulse = 0;
      passes(100);
      cmp("pulses", 15, nPulse); rdc(8'h2C, 15); rdc(8'h28, 100); irqc(1);
      wr(8'h34, 7); irqc(0);
      passes(30); rdc(8'h30, 30, 127);
      @(posedge clk) netClr <= 1;
      @(posedge clk) netClr <= 0;
      rdc(8'h30, 0, 127); passes(10); wr(8'h04, 15); rdc(8'h30, 0, 127);
      passes(5); wr(8'h00, 1); rdc(8'h28, 0); rdc(8'h2C, 0); rdc(8'h30, 0, 127);
      wr(8'h04, 0); nPulse = 0; passes(100); cmp("pulses", 0, nPulse);
      complete_run();
   end
endmodule : random_alarm_scheduler_bench
